// *** scc_config_regs.sv ***
`timescale 1ns/1ps
`include "scc_defines.svh"

module scc_config_regs (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   active_low_reset_pin,
  input  wire logic [1:0]             boost_strap_level,
  input  wire scc_pkg::scc_thr_strap_t rx_strap_level,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  output logic                        i2c_enabled,
  output logic                        config_hold,
  output logic [3:0]                  static_lift_level,
  output logic [7:0]                  receiver_threshold_level
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [3:0] boost_map(input logic [1:0] lvl);
    case (lvl)
      2'h0:    boost_map = `SCC_LIFT_LVL0;
      2'h1:    boost_map = `SCC_LIFT_LVL12;
      2'h2:    boost_map = `SCC_LIFT_LVL12;
      default: boost_map = `SCC_LIFT_LVL3;
    endcase
  endfunction : boost_map

  function automatic logic [7:0] thr_map(input scc_pkg::scc_thr_strap_t lvl);
    case (lvl)
      scc_pkg::SCC_THR_STRAP_MID:  thr_map = `SCC_THR_MID;
      scc_pkg::SCC_THR_STRAP_HIGH: thr_map = `SCC_THR_HIGH;
      default:                     thr_map = `SCC_THR_LOW;
    endcase
  endfunction : thr_map

  function automatic logic [7:0] read_reg(input logic [7:0] ofs, input scc_pkg::scc_regs_t r);
    case (ofs)
      `SCC_OFS_SETUP_CONTROL: read_reg = r.setup;
      `SCC_OFS_STATIC_LIFT:   read_reg = r.lift;
      `SCC_OFS_RX_THRESHOLD:  read_reg = r.thr;
      default:                read_reg = `SCC_UNMAPPED_READ;
    endcase
  endfunction : read_reg

  // ****************************************
  // state
  // ****************************************
  scc_pkg::scc_line_ev_t ev;
  scc_pkg::scc_regs_t    regs_r;
  scc_pkg::scc_state_t   state_r;
  logic [7:0]            shift_r;
  logic [3:0]            cnt_r;
  logic [7:0]            ptr_r;
  logic                  sda_low_r;
  logic                  ack_ok_r;
  logic [7:0]            smp_cnt_r;
  logic                  smp_done_r;
  logic                  i2c_en_r;
  logic                  loading;
  logic                  byte_done;
  logic                  addr_hit;
  logic                  wr_en;
  logic [7:0]            rd_first;
  logic [7:0]            rd_next;

  scc_line_monitor u_line (
    .ref_clk (ref_clk),
    .reset   (reset),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ev      (ev)
  );

  // shutdown while pin low, straps tracked until release
  assign loading   = reset | ~active_low_reset_pin;
  assign byte_done = ev.fall && (cnt_r == `SCC_BYTE_BITS);
  assign addr_hit  = i2c_en_r && (shift_r[7:1] == `SCC_I2C_ADDR);
  assign wr_en     = (state_r == scc_pkg::ST_WDATA) && byte_done;
  assign rd_first  = read_reg(ptr_r, regs_r);
  assign rd_next   = read_reg(ptr_r + 8'h01, regs_r);

  // ****************************************
  // serial port enable after shutdown
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (loading) begin
      smp_cnt_r  <= 8'h00;
      smp_done_r <= 1'b0;
      i2c_en_r   <= 1'b0;
    end else if (!smp_done_r) begin
      if (smp_cnt_r == 8'(`SCC_LINE_SAMPLE_CYC - 1)) begin
        smp_done_r <= 1'b1;
        i2c_en_r   <= scl_in & sda_in;
      end else begin
        smp_cnt_r <= smp_cnt_r + 8'h01;
      end
    end
  end

  // ****************************************
  // register bank
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (loading) begin
      regs_r.setup <= {`SCC_SETUP_RESV_RST, `SCC_HOLD_RST};
      regs_r.lift  <= {`SCC_LIFT_RESV_RST, boost_map(boost_strap_level)};
      regs_r.thr   <= thr_map(rx_strap_level);
    end else if (wr_en) begin
      case (ptr_r)
        `SCC_OFS_SETUP_CONTROL: regs_r.setup <= shift_r;
        `SCC_OFS_STATIC_LIFT:   regs_r.lift  <= shift_r;
        `SCC_OFS_RX_THRESHOLD:  regs_r.thr   <= shift_r;
        default: ;
      endcase
    end
  end

  // ****************************************
  // byte protocol engine
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (loading) begin
      state_r   <= scc_pkg::ST_IDLE;
      shift_r   <= 8'h00;
      cnt_r     <= 4'h0;
      ptr_r     <= 8'h00;
      sda_low_r <= 1'b0;
      ack_ok_r  <= 1'b0;
    end else if (ev.stop) begin
      state_r   <= scc_pkg::ST_IDLE;
      sda_low_r <= 1'b0;
    end else if (ev.start) begin
      state_r   <= scc_pkg::ST_ADDR;
      cnt_r     <= 4'h0;
      sda_low_r <= 1'b0;
    end else begin
      case (state_r)
        scc_pkg::ST_ADDR, scc_pkg::ST_PTR, scc_pkg::ST_WDATA: begin
          if (ev.rise && cnt_r != `SCC_BYTE_BITS) begin
            shift_r <= {shift_r[6:0], ev.sda};
            cnt_r   <= cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_r <= 4'h0;
            if (state_r == scc_pkg::ST_ADDR) begin
              if (addr_hit) begin
                sda_low_r <= 1'b1;
                state_r   <= scc_pkg::ST_ADDR_ACK;
              end else begin
                state_r <= scc_pkg::ST_IDLE;
              end
            end else if (state_r == scc_pkg::ST_PTR) begin
              ptr_r     <= shift_r;
              sda_low_r <= 1'b1;
              state_r   <= scc_pkg::ST_PTR_ACK;
            end else begin
              ptr_r     <= ptr_r + 8'h01;
              sda_low_r <= 1'b1;
              state_r   <= scc_pkg::ST_WDATA_ACK;
            end
          end
        end
        scc_pkg::ST_ADDR_ACK: begin
          if (ev.fall) begin
            cnt_r <= 4'h0;
            if (shift_r[0]) begin
              shift_r   <= {rd_first[6:0], 1'b0};
              sda_low_r <= ~rd_first[7];
              state_r   <= scc_pkg::ST_RDATA;
            end else begin
              sda_low_r <= 1'b0;
              state_r   <= scc_pkg::ST_PTR;
            end
          end
        end
        scc_pkg::ST_PTR_ACK, scc_pkg::ST_WDATA_ACK: begin
          if (ev.fall) begin
            sda_low_r <= 1'b0;
            state_r   <= scc_pkg::ST_WDATA;
          end
        end
        scc_pkg::ST_RDATA: begin
          if (ev.rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_r     <= 4'h0;
            sda_low_r <= 1'b0;
            state_r   <= scc_pkg::ST_RDATA_ACK;
          end else if (ev.fall) begin
            sda_low_r <= ~shift_r[7];
            shift_r   <= {shift_r[6:0], 1'b0};
          end
        end
        scc_pkg::ST_RDATA_ACK: begin
          if (ev.rise) begin
            ack_ok_r <= ~ev.sda;
          end else if (ev.fall) begin
            if (ack_ok_r) begin
              ptr_r     <= ptr_r + 8'h01;
              shift_r   <= {rd_next[6:0], 1'b0};
              sda_low_r <= ~rd_next[7];
              state_r   <= scc_pkg::ST_RDATA;
            end else begin
              state_r <= scc_pkg::ST_IDLE;
            end
          end
        end
        default: state_r <= scc_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign sda_out                  = 1'b0;
  assign sda_oe                   = sda_low_r;
  assign i2c_enabled              = i2c_en_r;
  assign config_hold              = regs_r.setup[`SCC_HOLD_BIT] & i2c_en_r;
  assign static_lift_level        = regs_r.lift[3:0];
  assign receiver_threshold_level = regs_r.thr;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_addr_byte_hit;
    (state_r == scc_pkg::ST_ADDR) && byte_done && addr_hit && !ev.stop && !ev.start && active_low_reset_pin;
  endsequence

  sequence s_ack_driven;
    (state_r == scc_pkg::ST_ADDR_ACK) && sda_oe;
  endsequence

  property p_hold_after_load;
    $fell(loading) |-> regs_r.setup[`SCC_HOLD_BIT] == 1'b1;
  endproperty
  a_hold_after_load: assert property (p_hold_after_load) else $error("hold bit not set after load");

  property p_lift_load;
    loading |=> regs_r.lift[3:0] == boost_map($past(boost_strap_level));
  endproperty
  a_lift_load: assert property (p_lift_load) else $error("lift level not loaded from strap");

  property p_thr_load;
    loading |=> regs_r.thr == thr_map($past(rx_strap_level));
  endproperty
  a_thr_load: assert property (p_thr_load) else $error("threshold not loaded from strap");

  property p_enable_sample;
    (!loading && !smp_done_r && smp_cnt_r == 8'(`SCC_LINE_SAMPLE_CYC - 1) && active_low_reset_pin)
      |=> i2c_en_r == ($past(scl_in) && $past(sda_in));
  endproperty
  a_enable_sample: assert property (p_enable_sample) else $error("serial enable sampled wrongly");

  property p_hold_gated;
    (wr_en && ptr_r == `SCC_OFS_SETUP_CONTROL && active_low_reset_pin)
      |=> {7'h00, config_hold} == ($past(shift_r) & 8'h01);
  endproperty
  a_hold_gated: assert property (p_hold_gated) else $error("hold output not following write");

  property p_addr_ack;
    s_addr_byte_hit |=> s_ack_driven;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("matching address not acknowledged");

  property p_no_ack_disabled;
    !i2c_en_r |-> state_r != scc_pkg::ST_ADDR_ACK;
  endproperty
  a_no_ack_disabled: assert property (p_no_ack_disabled) else $error("acknowledge while disabled");

  property p_write_lands;
    (wr_en && active_low_reset_pin && !ev.stop && !ev.start && ptr_r == `SCC_OFS_STATIC_LIFT)
      |=> regs_r.lift == $past(shift_r) ##1 1'b1;
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("written byte not stored");

  property p_regs_stable;
    (!wr_en && !loading) |=> $stable(regs_r);
  endproperty
  a_regs_stable: assert property (p_regs_stable) else $error("register changed without write");

endmodule : scc_config_regs

// *** scc_defines.svh ***
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define SCC_OFS_SETUP_CONTROL    8'h03
`define SCC_OFS_STATIC_LIFT      8'h0e
`define SCC_OFS_RX_THRESHOLD     8'h25
`define SCC_I2C_ADDR             7'h2c
`define SCC_HOLD_BIT             0
`define SCC_HOLD_RST             1'h1
`define SCC_SETUP_RESV_RST       7'h00
`define SCC_LIFT_RESV_RST        4'h0
`define SCC_UNMAPPED_READ        8'h00

// ****************************************
// strap codes
// ****************************************
`define SCC_LIFT_LVL0            4'h0
`define SCC_LIFT_LVL12           4'h2
`define SCC_LIFT_LVL3            4'h6
`define SCC_THR_LOW              8'h00
`define SCC_THR_MID              8'h33
`define SCC_THR_HIGH             8'h66

// ****************************************
// timing
// ****************************************
`define SCC_CLK_PERIOD_NS        10
`define SCC_LINE_SAMPLE_NS       1000
`define SCC_LINE_SAMPLE_CYC      ((`SCC_LINE_SAMPLE_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)
`define SCC_BYTE_BITS            4'h8

`endif

// *** scc_pkg.sv ***
package scc_pkg;

  typedef enum logic [1:0] {
    SCC_THR_STRAP_LOW,
    SCC_THR_STRAP_MID,
    SCC_THR_STRAP_HIGH
  } scc_thr_strap_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } scc_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } scc_line_ev_t;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] lift;
    logic [7:0] thr;
  } scc_regs_t;

endpackage : scc_pkg

// *** scc_line_monitor.sv ***
`timescale 1ns/1ps

// ****************************************
// serial line event detector
// ****************************************
module scc_line_monitor (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output scc_pkg::scc_line_ev_t     ev
);

  logic                 scl_q_r;
  logic                 sda_q_r;
  scc_pkg::scc_line_ev_t ev_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ev_r <= '0;
      ev_r.sda <= 1'b1;
    end else begin
      ev_r.start <= scl_q_r & scl_in & sda_q_r & ~sda_in;
      ev_r.stop  <= scl_q_r & scl_in & ~sda_q_r & sda_in;
      ev_r.rise  <= ~scl_q_r & scl_in;
      ev_r.fall  <= scl_q_r & ~scl_in;
      ev_r.sda   <= sda_in;
    end
  end

  assign ev = ev_r;

endmodule : scc_line_monitor

// *** scc_host_model.sv ***
`timescale 1ns/1ps

// ****************************************
// serial host, open-drain data
// ****************************************
module scc_host_model #(
  parameter int Q = 10
) (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt

  // data moves only while clock low
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    r = sda;
    wt(Q);
    scl <= 1'b0;
    wt(Q);
  endtask : bit_io

  task automatic start_c();
    sda_low <= 1'b0;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    sda_low <= 1'b1;
    wt(Q);
    scl <= 1'b0;
    wt(Q);
  endtask : start_c

  task automatic stop_c();
    sda_low <= 1'b1;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    sda_low <= 1'b0;
    wt(Q);
  endtask : stop_c

  // msb first, ninth bit is the acknowledge
  task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(mack, a);
    ack = ~a;
  endtask : byte_io
endmodule : scc_host_model

// *** testbench.sv ***
`timescale 1ns/1ps

module testbench;
  logic                    ref_clk;
  logic                    reset;
  logic                    active_low_reset_pin;
  logic [1:0]              boost_strap_level;
  scc_pkg::scc_thr_strap_t rx_strap_level;
  logic                    hold_low;
  logic                    scl;
  logic                    host_low;
  logic                    sda_out;
  logic                    sda_oe;
  logic                    i2c_enabled;
  logic                    config_hold;
  logic [3:0]              static_lift_level;
  logic [7:0]              receiver_threshold_level;
  logic [7:0]              v;
  logic [3:0]              lift_exp [4] = '{4'h0, 4'h2, 4'h2, 4'h6};
  logic [7:0]              thr_exp [4] = '{8'h00, 8'h33, 8'h66, 8'h00};
  int                      miscompares = 0;
  int                      comparisons = 0;
  int                      cycles = 0;
  wire logic               sda;

  // ****************************************
  // wired-and data line with pull-up
  // ****************************************
  assign sda = ~(host_low | (sda_oe & ~sda_out) | hold_low);

  scc_config_regs i_dut (
    .ref_clk                  (ref_clk),
    .reset                    (reset),
    .active_low_reset_pin     (active_low_reset_pin),
    .boost_strap_level        (boost_strap_level),
    .rx_strap_level           (rx_strap_level),
    .scl_in                   (scl),
    .sda_in                   (sda),
    .sda_out                  (sda_out),
    .sda_oe                   (sda_oe),
    .i2c_enabled              (i2c_enabled),
    .config_hold              (config_hold),
    .static_lift_level        (static_lift_level),
    .receiver_threshold_level (receiver_threshold_level)
  );

  scc_host_model #(.Q(10)) i_host (
    .ref_clk (ref_clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (host_low)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] adr, input logic [7:0] ofs, input logic [7:0] d, input logic ok);
    logic [7:0] b [3];
    logic [7:0] r;
    logic       a;
    b = '{adr, ofs, d};
    i_host.start_c();
    foreach (b[k]) begin
      i_host.byte_io(b[k], 1'b1, r, a);
      chk("ack", {7'h0, ok}, {7'h0, a});
    end
    i_host.stop_c();
  endtask : wr

  task automatic rd(input string n, input logic [7:0] ofs, input logic [7:0] exp, output logic [7:0] d);
    logic [7:0] r;
    logic       a;
    i_host.start_c();
    i_host.byte_io(8'h58, 1'b1, r, a);
    i_host.byte_io(ofs, 1'b1, r, a);
    i_host.start_c();
    i_host.byte_io(8'h59, 1'b1, r, a);
    i_host.byte_io(8'hff, 1'b1, d, a);
    i_host.stop_c();
    chk(n, exp, d);
  endtask : rd

  // pointer set, two bytes with host acknowledge between
  task automatic rd_burst(input logic [7:0] ofs, input logic [7:0] exp0, input logic [7:0] exp1);
    logic [7:0] r, d0, d1;
    logic       a;
    i_host.start_c();
    i_host.byte_io(8'h58, 1'b1, r, a);
    i_host.byte_io(ofs, 1'b1, r, a);
    i_host.start_c();
    i_host.byte_io(8'h59, 1'b1, r, a);
    i_host.byte_io(8'hff, 1'b0, d0, a);
    i_host.byte_io(8'hff, 1'b1, d1, a);
    i_host.stop_c();
    chk("burst0", exp0, d0);
    chk("burst1", exp1, d1);
  endtask : rd_burst

  // shutdown pulse with straps, optional data line held low
  task automatic boot(input int i, input logic ok);
    @(posedge ref_clk);
    active_low_reset_pin <= 1'b0;
    boost_strap_level    <= i[1:0];
    rx_strap_level       <= scc_pkg::scc_thr_strap_t'(i[1:0]);
    hold_low             <= ~ok;
    repeat (5) @(posedge ref_clk);
    active_low_reset_pin <= 1'b1;
    repeat (95) @(posedge ref_clk);
    #1;
    chk("early_enable", 8'h00, {7'h0, i2c_enabled});
    repeat (10) @(posedge ref_clk);
    #1;
    chk("enable", {7'h0, ok}, {7'h0, i2c_enabled});
    chk("hold", {7'h0, ok}, {7'h0, config_hold});
    chk("lift", {4'h0, lift_exp[i]}, {4'h0, static_lift_level});
    chk("thr", thr_exp[i], receiver_threshold_level);
    @(posedge ref_clk);
    hold_low <= 1'b0;
  endtask : boot

  initial begin
    reset                = 1'b1;
    active_low_reset_pin = 1'b1;
    boost_strap_level    = 2'h0;
    rx_strap_level       = scc_pkg::SCC_THR_STRAP_LOW;
    hold_low             = 1'b0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      boot(i, 1'b1);
      rd("lift_reg", 8'h0e, {4'h0, lift_exp[i]}, v);
      rd("thr_reg", 8'h25, thr_exp[i], v);
    end
    rd("setup_reg", 8'h03, 8'h01, v);
    wr(8'h58, 8'h25, 8'hff, 1'b1);
    chk("thr", 8'hff, receiver_threshold_level);
    rd("thr_reg", 8'h25, 8'hff, v);
    rd_burst(8'h24, 8'h00, 8'hff);
    rd("lift_reg", 8'h0e, 8'h06, v);
    wr(8'h58, 8'h0e, {v[7:4], 4'hf}, 1'b1);
    chk("lift", 8'h0f, {4'h0, static_lift_level});
    rd("setup_reg", 8'h03, 8'h01, v);
    wr(8'h58, 8'h03, {v[7:1], 1'b0}, 1'b1);
    chk("hold", 8'h00, {7'h0, config_hold});
    rd("setup_reg", 8'h03, 8'h00, v);
    wr(8'h58, 8'h03, {v[7:1], 1'b1}, 1'b1);
    chk("hold", 8'h01, {7'h0, config_hold});
    rd("unmapped", 8'h10, 8'h00, v);
    wr(8'h5a, 8'h25, 8'h12, 1'b0);
    chk("thr", 8'hff, receiver_threshold_level);
    boot(1, 1'b0);
    wr(8'h58, 8'h25, 8'h12, 1'b0);
    chk("thr", 8'h33, receiver_threshold_level);
    test_done();
  end
endmodule : testbench
